// [thermal_defines.svh]
// Offsets, field positions, reset values and thresholds of the thermal monitor.
`ifndef THERMAL_DEFINES_SVH
`define THERMAL_DEFINES_SVH

`define ADDR_W              4
`define OFS_CTRL            4'h0
`define OFS_TEMP            4'h1
`define OFS_STATUS          4'h2
`define OFS_SRC_SEL         4'h3
`define OFS_EVENT           4'h4
`define OFS_SETTINGS        4'h5
`define CTRL_EVT_EN_BIT     0
`define STAT_MODE_BIT       2
`define EVT_WARN_BIT        0
`define EVT_OVER_BIT        1
`define CTRL_RESET          8'h00
`define SETTINGS_RESET      8'h00
`define SRC_MAIN_BOARD      2'h0
`define TEMP_WARN_C         8'h51
`define TEMP_WARN_REARM_C   8'h4B
`define TEMP_OVER_C         8'h5A
`define TEMP_OVER_EXIT_C    8'h54
`define TEST_PATTERN_NUM    2'h2

`endif

// [thermal_pkg.sv]
// Types shared by the thermal monitor files.
package thermal_pkg;
    typedef enum logic [1:0]
    {
        COND_OK       = 2'b00,
        COND_CRITICAL = 2'b01,
        COND_ERROR    = 2'b10
    } thermal_condition_e;
    typedef logic [7:0] temp_t;
endpackage

// [rearm_flag.sv]
// One notification latch with a re-arm level.
`timescale 1ns/10ps
module rearm_flag
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                sample,
    input  wire logic                fire_cond,
    input  wire logic                rearm_cond,
    input  wire logic                enable,
    output logic                     pulse
);
    typedef struct packed
    {
        logic armed;
        logic pulse;
    } flag_s;

    flag_s s_q;
    flag_s s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.pulse = 1'b0;
        if (sample)
        begin
            if (s_q.armed && fire_cond)
            begin
                s_d.armed = 1'b0;
                s_d.pulse = enable;
            end
            else if (rearm_cond)
            begin
                s_d.armed = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{armed: 1'b1, pulse: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pulse = s_q.pulse;
endmodule

// [thermal_state_monitor.sv]
// Over-temperature supervisor: thresholds, condition, notifications, overheat mode.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "thermal_defines.svh"
module thermal_state_monitor
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    input  wire logic                    sample_valid,
    input  wire thermal_pkg::temp_t      sample_temp,
    input  wire logic [`ADDR_W-1:0]      reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [7:0]                   reg_rdata,
    output logic                         hot_warning_evt,
    output logic                         overheat_evt,
    output logic                         acquire_enable,
    output logic                         imager_power_on,
    output logic                         test_pattern_en,
    output logic [1:0]                   test_pattern_sel,
    output logic [7:0]                   active_settings
);
    import thermal_pkg::*;

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed
    {
        thermal_condition_e cond;
        temp_t              die_temp_reading;
        logic               overheat;
        logic               evt_en;
        logic [1:0]         temp_source_select;
        logic [7:0]         settings;
        logic [7:0]         rdata;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic   warn_pulse;
    logic   over_pulse;

    always_comb
    begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        if (sample_valid)
        begin
            s_d.die_temp_reading = sample_temp;
            // Each new reading walks the hysteresis ladder once, so a jump over several
            // thresholds settles at the right condition in a single step.
            case (s_q.cond)
                COND_OK:
                begin
                    if (sample_temp >= `TEMP_OVER_C)
                    begin
                        s_d.cond = COND_ERROR;
                        s_d.overheat = 1'b1;
                    end
                    else if (sample_temp >= `TEMP_WARN_C)
                    begin
                        s_d.cond = COND_CRITICAL;
                    end
                end
                COND_CRITICAL:
                begin
                    if (sample_temp >= `TEMP_OVER_C)
                    begin
                        s_d.cond = COND_ERROR;
                        s_d.overheat = 1'b1;
                    end
                    else if (sample_temp <= `TEMP_WARN_REARM_C)
                    begin
                        s_d.cond = COND_OK;
                    end
                end
                COND_ERROR:
                begin
                    if (sample_temp <= `TEMP_WARN_REARM_C)
                    begin
                        s_d.cond = COND_OK;
                        s_d.overheat = 1'b0;
                    end
                    else if (sample_temp <= `TEMP_OVER_EXIT_C)
                    begin
                        s_d.cond = COND_CRITICAL;
                        s_d.overheat = 1'b0;
                    end
                end
                default:
                begin
                    s_d.cond = COND_OK;
                    s_d.overheat = 1'b0;
                end
            endcase
        end
        if (reg_wr)
        begin
            case (reg_addr)
                `OFS_CTRL:
                begin
                    s_d.evt_en = reg_wdata[`CTRL_EVT_EN_BIT];
                end
                `OFS_SRC_SEL:
                begin
                    // Only the main board sensor exists; other codes are ignored.
                    if (reg_wdata[1:0] == `SRC_MAIN_BOARD)
                    begin
                        s_d.temp_source_select = reg_wdata[1:0];
                    end
                end
                `OFS_SETTINGS:
                begin
                    s_d.settings = reg_wdata;
                end
                default:
                begin
                end
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                `OFS_CTRL:     s_d.rdata = {7'h00, s_q.evt_en};
                `OFS_TEMP:     s_d.rdata = s_q.die_temp_reading;
                `OFS_STATUS:   s_d.rdata = {5'h00, s_q.overheat, s_q.cond};
                `OFS_SRC_SEL:  s_d.rdata = {6'h00, s_q.temp_source_select};
                `OFS_EVENT:    s_d.rdata = {6'h00, over_pulse, warn_pulse};
                `OFS_SETTINGS: s_d.rdata = s_q.settings;
                default:       s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{cond: COND_OK, die_temp_reading: 8'h00, overheat: 1'b0,
                     evt_en: 1'b0, temp_source_select: `SRC_MAIN_BOARD,
                     settings: `SETTINGS_RESET, rdata: 8'h00};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Notifications
    // ************************************************************
    logic warn_fire;
    logic over_fire;

    assign warn_fire = sample_valid && (s_d.cond != COND_OK) && (s_q.cond == COND_OK);
    assign over_fire = sample_valid && s_d.overheat && !s_q.overheat;

    rearm_flag u_warn
    (
        .clk        (ref_clk),
        .rst_n      (rst_n),
        .sample     (sample_valid),
        .fire_cond  (warn_fire),
        .rearm_cond (sample_temp <= `TEMP_WARN_REARM_C),
        .enable     (s_q.evt_en),
        .pulse      (warn_pulse)
    );

    rearm_flag u_over
    (
        .clk        (ref_clk),
        .rst_n      (rst_n),
        .sample     (sample_valid),
        .fire_cond  (over_fire),
        .rearm_cond (sample_temp <= `TEMP_OVER_EXIT_C),
        .enable     (s_q.evt_en),
        .pulse      (over_pulse)
    );

    assign hot_warning_evt = warn_pulse;
    assign overheat_evt    = over_pulse;

    // ************************************************************
    // Overheat mode outputs
    // ************************************************************
    // Settings stay in their register through overheat, so normal operation resumes
    // with exactly what was in force before; only the gating below changes.
    assign acquire_enable   = !s_q.overheat;
    assign imager_power_on  = !s_q.overheat;
    assign test_pattern_en  = s_q.overheat;
    assign test_pattern_sel = s_q.overheat ? `TEST_PATTERN_NUM : 2'h0;
    assign active_settings  = s_q.settings;
    assign reg_rdata        = s_q.rdata;

    // ************************************************************
    // Checks
    // ************************************************************
    cond_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_valid && s_q.cond == COND_OK && sample_temp >= `TEMP_WARN_C
        && sample_temp < `TEMP_OVER_C |=> s_q.cond == COND_CRITICAL)
        else $error("OK did not become critical at 81.");

    overheat_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_valid && s_q.cond != COND_ERROR && sample_temp >= `TEMP_OVER_C
        |=> s_q.cond == COND_ERROR && s_q.overheat)
        else $error("Overheat not entered at 90.");

    overheat_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_valid && s_q.cond == COND_ERROR && sample_temp <= `TEMP_OVER_EXIT_C
        && sample_temp > `TEMP_WARN_REARM_C |=> s_q.cond == COND_CRITICAL && !s_q.overheat)
        else $error("Overheat not left at 84.");

    cool_ok_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_valid && s_q.cond == COND_CRITICAL && sample_temp <= `TEMP_WARN_REARM_C
        |=> s_q.cond == COND_OK)
        else $error("Critical not cleared at 75.");

    crit_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_valid && s_q.cond == COND_CRITICAL && sample_temp > `TEMP_WARN_REARM_C
        && sample_temp < `TEMP_OVER_C |=> s_q.cond == COND_CRITICAL)
        else $error("Critical left inside its band.");

    overheat_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_valid && s_q.overheat && sample_temp > `TEMP_OVER_EXIT_C
        |=> s_q.overheat && s_q.cond == COND_ERROR)
        else $error("Overheat left above 84.");

    warn_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        warn_pulse
        |=> !warn_pulse)
        else $error("Warning notice repeated.");

    warn_on_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_valid && s_q.cond == COND_OK && sample_temp >= `TEMP_WARN_C && s_q.evt_en
        |=> hot_warning_evt)
        else $error("Warning notice missing on leaving OK.");

    warn_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hot_warning_evt
        |-> $past(s_q.cond) == COND_OK && s_q.cond != COND_OK)
        else $error("Warning notice without leaving OK.");

    // The re-arm checks look inside the latches, since arming leaves no trace at the pins.
    warn_rearm_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(u_warn.s_q.armed)
        |-> $past(sample_valid) && $past(sample_temp) <= `TEMP_WARN_REARM_C)
        else $error("Warning re-armed above 75.");

    over_on_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_valid && !s_q.overheat && sample_temp >= `TEMP_OVER_C && s_q.evt_en
        |=> overheat_evt)
        else $error("Overheat notice missing on entry.");

    over_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        overheat_evt
        |-> s_q.overheat && !$past(s_q.overheat))
        else $error("Overheat notice without entry.");

    over_rearm_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(u_over.s_q.armed)
        |-> $past(sample_valid) && $past(sample_temp) <= `TEMP_OVER_EXIT_C)
        else $error("Overheat notice re-armed above 84.");

    evt_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (warn_pulse || over_pulse)
        |-> $past(s_q.evt_en))
        else $error("Notice sent while disabled.");

    pattern_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_q.overheat |-> test_pattern_sel == `TEST_PATTERN_NUM && test_pattern_en
        && !acquire_enable && !imager_power_on)
        else $error("Overheat outputs wrong.");

    mode_normal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !s_q.overheat |-> acquire_enable && imager_power_on
        && !test_pattern_en && test_pattern_sel == 2'h0)
        else $error("Normal mode outputs wrong.");

    cond_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_q.cond != 2'h3)
        else $error("Illegal condition code.");

    no_sample_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !sample_valid
        |=> $stable(s_q.cond) && $stable(s_q.overheat))
        else $error("Condition moved without a reading.");

    temp_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_valid
        |=> s_q.die_temp_reading == $past(sample_temp))
        else $error("Reading not captured.");

    src_fixed_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_q.temp_source_select == `SRC_MAIN_BOARD)
        else $error("Unknown temperature source selected.");

    status_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == `OFS_STATUS
        |=> reg_rdata == {5'h00, $past(s_q.overheat), $past(s_q.cond)})
        else $error("Status read wrong.");

    rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !reg_rd
        |=> reg_rdata == 8'h00)
        else $error("Read data outside its cycle.");

    settings_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && reg_addr == `OFS_SETTINGS
        |=> active_settings == $past(reg_wdata))
        else $error("Settings write lost.");

    settings_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(s_q.overheat)
        |-> active_settings == $past(active_settings))
        else $error("Settings changed on overheat exit.");
endmodule

// [host_model.sv]
// Host-side model: register bus master and listener for notification pulses.
`timescale 1ns/10ps
`include "thermal_defines.svh"
module host_model
(
    input  wire logic                ref_clk,
    output logic [`ADDR_W-1:0]       reg_addr,
    output logic [7:0]               reg_wdata,
    output logic                     reg_wr,
    output logic                     reg_rd,
    input  wire logic [7:0]          reg_rdata,
    input  wire logic                hot_warning_evt,
    input  wire logic                overheat_evt
);
    int warn_count = 0;
    int over_count = 0;

    initial
    begin
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // The host only hears what the device sends; pulses are counted as they arrive.
    always @(posedge ref_clk)
    begin
        if (hot_warning_evt === 1'b1) warn_count++;
        if (overheat_evt === 1'b1) over_count++;
    end

    task automatic reg_write(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic reg_read(input logic [`ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// [tb_top.sv]
// Self-checking testbench of the thermal state monitor.
`timescale 1ns/10ps
`include "thermal_defines.svh"
`define CHECK(what, exp, got) \
    begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
    import thermal_pkg::*;
    logic                ref_clk = 1'b0;
    logic                reset_n = 1'b1;
    logic                sample_valid = 1'b0;
    temp_t               sample_temp = 8'h00;
    logic [`ADDR_W-1:0]  reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_rdata;
    logic                hot_warning_evt;
    logic                overheat_evt;
    logic                acquire_enable;
    logic                imager_power_on;
    logic                test_pattern_en;
    logic [1:0]          test_pattern_sel;
    logic [7:0]          active_settings;
    int                  n_mismatch = 0;
    int                  check_count = 0;
    int                  cycle_count = 0;

    always #50 ref_clk = ~ref_clk;

    thermal_state_monitor u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .sample_valid(sample_valid), .sample_temp(sample_temp), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hot_warning_evt(hot_warning_evt), .overheat_evt(overheat_evt),
        .acquire_enable(acquire_enable), .imager_power_on(imager_power_on),
        .test_pattern_en(test_pattern_en), .test_pattern_sel(test_pattern_sel),
        .active_settings(active_settings));

    host_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hot_warning_evt(hot_warning_evt), .overheat_evt(overheat_evt));

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Feeds one reading, then checks the pulses in their one cycle and after it.
    task automatic apply(input temp_t t, input logic w, input logic o);
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        sample_temp  <= t;
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        #1;
        `CHECK("hot_warning_evt", w, hot_warning_evt)
        `CHECK("overheat_evt", o, overheat_evt)
        @(posedge ref_clk);
        #1;
        `CHECK("pulse end", 2'b00, {hot_warning_evt, overheat_evt})
    endtask

    task automatic expect_reg(input logic [`ADDR_W-1:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.reg_read(a, d);
        `CHECK("register", e, d)
    endtask

    task automatic expect_mode(input logic ovh);
        `CHECK("acquire_enable", ~ovh, acquire_enable)
        `CHECK("imager_power_on", ~ovh, imager_power_on)
        `CHECK("test_pattern_en", ovh, test_pattern_en)
        `CHECK("test_pattern_sel", ovh ? `TEST_PATTERN_NUM : 2'h0, test_pattern_sel)
    endtask

    task automatic t_reset_values();
        expect_mode(1'b0);
        `CHECK("active_settings", `SETTINGS_RESET, active_settings)
        expect_reg(`OFS_CTRL, `CTRL_RESET);
        expect_reg(`OFS_STATUS, {5'h00, 1'b0, COND_OK});
    endtask

    task automatic t_events_disabled();
        apply(8'h51, 1'b0, 1'b0);
        expect_reg(`OFS_STATUS, {5'h00, 1'b0, COND_CRITICAL});
        apply(8'h3C, 1'b0, 1'b0);
        expect_reg(`OFS_STATUS, {5'h00, 1'b0, COND_OK});
    endtask

    task automatic t_overheat_entry();
        u_host.reg_write(`OFS_CTRL, 8'h01);
        u_host.reg_write(`OFS_SETTINGS, 8'hA5);
        apply(8'h50, 1'b0, 1'b0);
        apply(8'h51, 1'b1, 1'b0);
        apply(8'h55, 1'b0, 1'b0);
        apply(8'h5A, 1'b0, 1'b1);
        expect_mode(1'b1);
        expect_reg(`OFS_STATUS, {5'h00, 1'b1, COND_ERROR});
        `CHECK("active_settings", 8'hA5, active_settings)
    endtask

    task automatic t_overheat_exit();
        apply(8'h5B, 1'b0, 1'b0);
        apply(8'h55, 1'b0, 1'b0);
        expect_reg(`OFS_STATUS, {5'h00, 1'b1, COND_ERROR});
        apply(8'h54, 1'b0, 1'b0);
        expect_mode(1'b0);
        expect_reg(`OFS_STATUS, {5'h00, 1'b0, COND_CRITICAL});
        `CHECK("active_settings", 8'hA5, active_settings)
        apply(8'h5A, 1'b0, 1'b1);
        apply(8'h54, 1'b0, 1'b0);
    endtask

    task automatic t_cool_and_jump();
        apply(8'h4C, 1'b0, 1'b0);
        expect_reg(`OFS_STATUS, {5'h00, 1'b0, COND_CRITICAL});
        apply(8'h4B, 1'b0, 1'b0);
        expect_reg(`OFS_STATUS, {5'h00, 1'b0, COND_OK});
        u_host.reg_write(`OFS_SRC_SEL, `SRC_MAIN_BOARD);
        expect_reg(`OFS_TEMP, 8'h4B);
        apply(8'h5F, 1'b1, 1'b1);
        expect_reg(`OFS_STATUS, {5'h00, 1'b1, COND_ERROR});
        apply(8'h3C, 1'b0, 1'b0);
        expect_reg(`OFS_STATUS, {5'h00, 1'b0, COND_OK});
    endtask

    task automatic t_source_select();
        u_host.reg_write(`OFS_SRC_SEL, 8'h01);
        expect_reg(`OFS_SRC_SEL, 8'h00);
        expect_reg(4'h9, 8'h00);
        `CHECK("warnings heard", 2, u_host.warn_count)
        `CHECK("overheats heard", 3, u_host.over_count)
    endtask

    // The event register shows a pulse only in its one cycle, so the read strobe is
    // raised at the edge that takes the reading and sampled at the next edge, in the pulse's cycle.
    task automatic t_event_reg();
        logic [7:0] d;
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        sample_temp  <= 8'h51;
        fork
            u_host.reg_read(`OFS_EVENT, d);
            begin
                @(posedge ref_clk);
                sample_valid <= 1'b0;
            end
        join
        `CHECK("event register", 8'h01, d)
    endtask

    // The whole run needs under a hundred cycles; the ceiling leaves ample margin.
    always @(posedge ref_clk)
    begin
        cycle_count++;
        if (cycle_count == 3000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    initial
    begin
        // A real falling edge at time zero clears the reset chain before the first
        // clock edge, so no check ever samples unknown state.
        reset_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        t_reset_values();
        t_events_disabled();
        t_overheat_entry();
        t_overheat_exit();
        t_cool_and_jump();
        t_source_select();
        t_event_reg();
        summarize();
    end
endmodule
